/* clk_sel_pkg.sv */
// constants for the system clock source select block
// assumes a 32-bit avalon-mm slave and an 8-bit select register
package clk_sel_pkg;

   // register byte offsets
   localparam logic [3:0] off_clock_source_select = 4'h0;
   localparam logic [3:0] off_write_protect       = 4'h4;
   localparam logic [3:0] off_watchdog_control    = 4'h8;
   localparam logic [3:0] off_status              = 4'hC;

   // clock_source_select field positions
   localparam int bit_sys_clk_from_pll        = 7;
   localparam int bit_osc_runs_in_stop        = 6;
   localparam int bit_presc_in_stop           = 3;
   localparam int bit_wdog_in_stop_enable     = 2;
   localparam int bit_periodic_timer_clk_src  = 1;
   localparam int bit_watchdog_clk_src        = 0;

   // bits writable in normal mode, watchdog source handled apart
   localparam logic [7:0] normal_write_mask = 8'hCE;
   // bits that exist; 5:4 read as zero
   localparam logic [7:0] implemented_mask  = 8'hCF;

   // status register field positions
   localparam int bit_osc_good_status   = 0;
   localparam int bit_special_mode      = 1;
   localparam int bit_full_stop         = 2;
   localparam int bit_wdog_written      = 3;
   localparam int bit_wdog_rearm        = 4;

   // reset values
   localparam logic [7:0] clks_reset      = 8'h80;
   localparam logic [7:0] wdog_ctrl_reset = 8'h00;
   localparam logic       write_protect_bit_reset      = 1'h0;

   localparam int data_width = 32;
   localparam int byte_width = 8;

endpackage : clk_sel_pkg

/* bus_clk_divider.sv */
// divide-by-two phase generator for the bus clock
// assumes core_clk is the fast source; the phase marks bus clock edges
`timescale 1ns/1ps
`default_nettype none
module bus_clk_divider
(
   // clock and reset
   input  wire  logic core_clk,
   input  wire  logic rst_n,
   // divided phase
   output logic       bus_phase
);

   typedef struct packed
   {
      logic phase;
   } div_state_s;

   div_state_s state;
   div_state_s next_state;

   // toggle each cycle, half the source rate
   always_comb
   begin
      next_state       = state;
      next_state.phase = ~state.phase; // R11
   end

   // state register
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign bus_phase = state.phase;

endmodule : bus_clk_divider
`default_nettype wire

/* system_clock_source_select.sv */
// system clock source select: one 8-bit select register with
// write protection, mode gating and forced hardware updates
// assumes avalon-mm master on core_clk; pins are asynchronous
//
// Summary of operation
// R1: writes to the select register are ignored while protection is set
// R2: special mode lets every select bit be written, protection aside
// R3: normal mode writes source, stop-osc, prescaler, enable, timer bits
// R4: normal mode watchdog source writable only before watchdog write-once
// R5: falling oscillator-good clears the watchdog source bit
// R6: after that clear, software may set the watchdog source once more
// R7: software should read back the register after each write
// R8: pll select bit clears to 0 only while oscillator good
// R9: oscillator not good forces pll select bit to 1
// R10: entering full stop sets pll select bit
// R11: select 1 uses pll clock, 0 the oscillator, bus at half rate
// R12: stop-osc bit 0 stops oscillator in stop, 1 keeps it running
// R13: software waits oscillator startup time before pseudo stop
// R14: register always readable; rejected writes change nothing
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_select
(
   // clock and reset
   input  wire  logic        core_clk,
   input  wire  logic        rst_n,
   // avalon-mm slave
   input  wire  logic [3:0]  address,
   input  wire  logic        read,
   input  wire  logic        write,
   input  wire  logic [31:0] writedata,
   input  wire  logic [3:0]  byteenable,
   output logic [31:0]       readdata,
   output logic              waitrequest,
   // asynchronous status pins
   input  wire  logic        osc_good_status,
   input  wire  logic        special_mode,
   input  wire  logic        stop_request,
   // clock control outputs
   output logic              sys_clk_from_pll,
   output logic              osc_run,
   output logic              full_stop,
   output logic              pseudo_stop,
   output logic              bus_phase,
   output logic [7:0]        clock_source_select,
   output logic [7:0]        watchdog_control_reg
);

   typedef struct packed
   {
      logic        ack;
      logic [31:0] rdata;
      logic [7:0]  clks;
      logic        write_protect_bit;
      logic [7:0]  wdog_ctrl;
      logic        wdog_written;
      logic        wdog_rearm;
      logic        osc_s1;
      logic        osc_s2;
      logic        osc_prev;
      logic        mode_s1;
      logic        mode_s2;
      logic        stop_s1;
      logic        stop_s2;
      logic        stop_prev;
      logic        full_stop;
      logic        pseudo_stop;
   } sel_state_s;

   sel_state_s state;
   sel_state_s next_state;

   // merge byte lane zero of a write into an 8-bit value under a mask
   function automatic logic [7:0] merge_byte
   (
      input logic [7:0] old_val,
      input logic [7:0] new_val,
      input logic [7:0] mask
   );
      merge_byte = (old_val & ~mask) | (new_val & mask);
   endfunction : merge_byte

   // widen an 8-bit register value onto the data bus
   function automatic logic [31:0] widen
   (
      input logic [7:0] val
   );
      widen = {{(clk_sel_pkg::data_width - clk_sel_pkg::byte_width){1'b0}},
               val};
   endfunction : widen

   logic       take;
   logic       wr_go;
   logic       osc_good;
   logic       osc_fall;
   logic       stop_rise;
   logic       special;
   logic [7:0] wmask;
   logic [7:0] wbyte;
   logic [7:0] status_byte;

   // request taken on the second cycle, one wait state
   assign take        = (read | write) & state.ack;
   assign wr_go       = write & state.ack & byteenable[0];
   assign waitrequest = (read | write) & ~state.ack;
   assign osc_good    = state.osc_s2;
   assign special     = state.mode_s2;
   assign osc_fall    = state.osc_prev & ~state.osc_s2;
   assign stop_rise   = state.stop_s2 & ~state.stop_prev;
   assign wbyte       = writedata[7:0];

   // status byte shows the block's own state
   always_comb
   begin
      status_byte = '0;
      status_byte[clk_sel_pkg::bit_osc_good_status] = osc_good;
      status_byte[clk_sel_pkg::bit_special_mode]    = special;
      status_byte[clk_sel_pkg::bit_full_stop]       = state.full_stop;
      status_byte[clk_sel_pkg::bit_wdog_written]    = state.wdog_written;
      status_byte[clk_sel_pkg::bit_wdog_rearm]      = state.wdog_rearm;
   end

   // which select bits a write may touch in the current mode
   always_comb
   begin
      if (special)
      begin
         wmask = clk_sel_pkg::implemented_mask; // R2
      end
      else
      begin
         wmask = clk_sel_pkg::normal_write_mask; // R3
         if (!state.wdog_written || state.wdog_rearm)
         begin
            wmask[clk_sel_pkg::bit_watchdog_clk_src] = 1'b1; // R4 R6
         end
      end
   end

   // next state: bus, registers, forced updates, synchronisers
   always_comb
   begin
      next_state = state;

      // two-flop synchronisers; the first stage feeds only the second
      next_state.osc_s1    = osc_good_status;
      next_state.osc_s2    = state.osc_s1;
      next_state.osc_prev  = state.osc_s2;
      next_state.mode_s1   = special_mode;
      next_state.mode_s2   = state.mode_s1;
      next_state.stop_s1   = stop_request;
      next_state.stop_s2   = state.stop_s1;
      next_state.stop_prev = state.stop_s2;

      // handshake: assert ack for one cycle per request
      next_state.ack = (read | write) & ~state.ack;

      // read data captured in the wait cycle, stands at the taking edge
      if ((read) && (!state.ack))
      begin
         if (address == clk_sel_pkg::off_clock_source_select)
         begin
            next_state.rdata = widen(state.clks); // R14
         end
         else if (address == clk_sel_pkg::off_write_protect)
         begin
            next_state.rdata = widen({7'h00, state.write_protect_bit});
         end
         else if (address == clk_sel_pkg::off_watchdog_control)
         begin
            next_state.rdata = widen(state.wdog_ctrl);
         end
         else if (address == clk_sel_pkg::off_status)
         begin
            next_state.rdata = widen(status_byte);
         end
         else
         begin
            next_state.rdata = '0; // unmapped reads zero
         end
      end

      // register writes at the edge where waitrequest is low
      if (wr_go)
      begin
         if (address == clk_sel_pkg::off_clock_source_select)
         begin
            if (!state.write_protect_bit) // R1
            begin
               next_state.clks = merge_byte(state.clks, wbyte, wmask);
               // pll select may drop only with a good oscillator
               if (!osc_good)
               begin
                  next_state.clks[clk_sel_pkg::bit_sys_clk_from_pll] =
                     state.clks[clk_sel_pkg::bit_sys_clk_from_pll]; // R8
               end
               // the rearm is spent by a set taken on its strength
               if (!special && state.wdog_written && state.wdog_rearm &&
                   wbyte[clk_sel_pkg::bit_watchdog_clk_src])
               begin
                  next_state.wdog_rearm = 1'b0; // R6
               end
            end
         end
         else if (address == clk_sel_pkg::off_write_protect)
         begin
            next_state.write_protect_bit = wbyte[0];
         end
         else if (address == clk_sel_pkg::off_watchdog_control)
         begin
            // write once in normal mode, any time in special mode
            if (special || !state.wdog_written)
            begin
               next_state.wdog_ctrl = wbyte;
            end
            if (!special)
            begin
               next_state.wdog_written = 1'b1; // R4
            end
         end
      end

      // stop entry decides full or pseudo stop from the stop-osc bit
      if (stop_rise)
      begin
         if (state.clks[clk_sel_pkg::bit_osc_runs_in_stop])
         begin
            next_state.pseudo_stop = 1'b1; // R12
         end
         else
         begin
            next_state.full_stop = 1'b1; // R12
            next_state.clks[clk_sel_pkg::bit_sys_clk_from_pll] = 1'b1; // R10
         end
      end
      else if (!state.stop_s2)
      begin
         next_state.full_stop   = 1'b0;
         next_state.pseudo_stop = 1'b0;
      end

      // loss of oscillator: clear watchdog source, allow one re-set
      if (osc_fall)
      begin
         if (state.clks[clk_sel_pkg::bit_watchdog_clk_src])
         begin
            next_state.wdog_rearm = 1'b1; // R6
         end
         next_state.clks[clk_sel_pkg::bit_watchdog_clk_src] = 1'b0; // R5
      end

      // hardware force last so it wins over a software clear
      if (!osc_good)
      begin
         next_state.clks[clk_sel_pkg::bit_sys_clk_from_pll] = 1'b1; // R9
      end

      // unimplemented bits stay zero whatever is written
      next_state.clks = next_state.clks & clk_sel_pkg::implemented_mask;
   end

   // single state register
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state           <= '0;
         state.clks      <= clk_sel_pkg::clks_reset;
         state.write_protect_bit      <= clk_sel_pkg::write_protect_bit_reset;
         state.wdog_ctrl <= clk_sel_pkg::wdog_ctrl_reset;
      end
      else
      begin
         state <= next_state;
      end
   end

   // bus phase toggles at half the core_clk rate, whatever source is selected
   bus_clk_divider u_div
   (
      .core_clk  (core_clk),
      .rst_n     (rst_n),
      .bus_phase (bus_phase) // R11
   );

   // outputs straight from flops, except osc_run, the inverse of the full stop flop
   assign readdata             = state.rdata;
   assign clock_source_select  = state.clks; // R7
   assign watchdog_control_reg = state.wdog_ctrl;
   assign sys_clk_from_pll =
      state.clks[clk_sel_pkg::bit_sys_clk_from_pll]; // R11
   assign full_stop   = state.full_stop;
   assign pseudo_stop = state.pseudo_stop;
   assign osc_run     = ~state.full_stop; // R12

   // take is the bus completion edge, kept for clarity of timing
   logic unused_take;
   assign unused_take = take;

endmodule : system_clock_source_select
`default_nettype wire

/* clk_sel_monitor.sv */
// checker for the clock select block, top-level ports only
// assumes one core_clk domain and active-low rst_n
`timescale 1ns/1ps
`default_nettype none
module clk_sel_monitor
(
   // clock and reset
   input wire logic        core_clk,
   input wire logic        rst_n,
   // bus
   input wire logic [3:0]  address,
   input wire logic        read,
   input wire logic        write,
   input wire logic [31:0] readdata,
   input wire logic        waitrequest,
   // pins and outputs
   input wire logic        osc_good_status,
   input wire logic        stop_request,
   input wire logic        sys_clk_from_pll,
   input wire logic        osc_run,
   input wire logic        full_stop,
   input wire logic        pseudo_stop,
   input wire logic        bus_phase,
   input wire logic [7:0]  clock_source_select
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // stop entry, then a stop state within the sync lag
   sequence s_entry; $rose(stop_request); endsequence
   sequence s_stopped; ##[1:6] (full_stop || pseudo_stop); endsequence
   property p_ack; (read || write) && waitrequest |=> !waitrequest; endproperty
   a_ack: assert property (p_ack) else $error("no answer");
   property p_rd;
      read && !waitrequest && address == 4'h0
         |-> readdata == {24'h0, clock_source_select};
   endproperty
   a_rd: assert property (p_rd) else $error("bad read data");
   property p_rsvd; clock_source_select[5:4] == 2'b00; endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved set");
   property p_src; sys_clk_from_pll == clock_source_select[7]; endproperty
   a_src: assert property (p_src) else $error("source mismatch");
   // pin lag is two flops, so allow five low samples
   property p_force; !osc_good_status [*5] |=> clock_source_select[7];
   endproperty
   a_force: assert property (p_force) else $error("pll not forced");
   property p_wdog; $fell(osc_good_status) |-> ##[1:5] !clock_source_select[0];
   endproperty
   a_wdog: assert property (p_wdog) else $error("wdog src kept");
   property p_clear;
      $fell(clock_source_select[7])
         |-> $past(osc_good_status, 2) || $past(osc_good_status, 3);
   endproperty
   a_clear: assert property (p_clear) else $error("bad pll clear");
   property p_fstop; $rose(full_stop) |-> !osc_run ##1 clock_source_select[7];
   endproperty
   a_fstop: assert property (p_fstop) else $error("full stop");
   property p_pstop; pseudo_stop |-> osc_run && !full_stop; endproperty
   a_pstop: assert property (p_pstop) else $error("pseudo stop");
   property p_stop; s_entry |-> s_stopped; endproperty
   a_stop: assert property (p_stop) else $error("no stop state");
   // skip the first edge after reset, where the divider is still held
   property p_phase; $past(rst_n) |-> bus_phase != $past(bus_phase);
   endproperty
   a_phase: assert property (p_phase) else $error("no half rate");
endmodule : clk_sel_monitor

bind system_clock_source_select clk_sel_monitor i_clk_sel_monitor
(
   .core_clk, .rst_n, .address, .read, .write, .readdata, .waitrequest,
   .osc_good_status, .stop_request, .sys_clk_from_pll, .osc_run,
   .full_stop, .pseudo_stop, .bus_phase, .clock_source_select
);
`default_nettype wire

/* system_clock_source_select_tb.sv */
// self-checking bench for the clock select block
// assumes the package and design are compiled first
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_select_tb;
   logic        core_clk, rst_n, read, write, waitrequest;
   logic [3:0]  address, byteenable;
   logic [31:0] writedata, readdata, q;
   logic        osc_good_status, special_mode, stop_request;
   logic        sys_clk_from_pll, osc_run, full_stop, pseudo_stop;
   logic        bus_phase;
   logic [7:0]  clock_source_select, watchdog_control_reg;
   int          n_fail, comparisons;

   system_clock_source_select i_system_clock_source_select
   (
      .core_clk, .rst_n, .address, .read, .write, .writedata, .byteenable,
      .readdata, .waitrequest, .osc_good_status, .special_mode,
      .stop_request, .sys_clk_from_pll, .osc_run, .full_stop,
      .pseudo_stop, .bus_phase, .clock_source_select, .watchdog_control_reg
   );

   // 200 MHz core clock
   initial
   begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
         n_fail++;
      end
   endtask : chk

   // one transfer, held until waitrequest is sampled low
   task automatic bus(input logic [3:0] a, input logic w,
                      input logic [7:0] d, input logic [3:0] be);
      int   n;
      logic wq;
      n  = 0;
      wq = 1'b1;
      @(posedge core_clk);
      address    <= a;
      read       <= ~w;
      write      <= w;
      writedata  <= {24'h0, d};
      byteenable <= be;
      // look mid-cycle where outputs are settled; the next edge takes it
      do
      begin
         @(negedge core_clk);
         n++;
         wq = waitrequest;
         q  = readdata;
         @(posedge core_clk);
      end
      while (wq !== 1'b0 && n < 16);
      read  <= 1'b0;
      write <= 1'b0;
      if (wq !== 1'b0)
      begin
         n_fail++;
         tally_and_finish();
      end
   endtask : bus

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus(a, 1'b1, d, 4'h1);
   endtask : wr

   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      bus(a, 1'b0, 8'h00, 4'hF);
      chk(q, e);
   endtask : rd

   // pins pass two sync flops, so settle a few cycles
   task automatic nap(input int k);
      repeat (k) @(posedge core_clk);
   endtask : nap

   // main sequence; each group of checks ends with a test done message
   initial
   begin
      n_fail = 0;
      comparisons = 0;
      rst_n = 1'b0;
      {address, read, write, writedata, byteenable} = '0;
      {osc_good_status, special_mode, stop_request} = 3'b100;
      nap(4);
      rst_n <= 1'b1;
      rd(4'h0, 32'h80);
      $display("test reset done");
      wr(4'h0, 8'h00);
      rd(4'h0, 32'h00);
      osc_good_status <= 1'b0;
      nap(6);
      rd(4'h0, 32'h80);
      wr(4'h0, 8'h00);
      rd(4'h0, 32'h80);
      osc_good_status <= 1'b1;
      nap(6);
      $display("test osc gate done");
      wr(4'h0, 8'hFF);
      rd(4'h0, 32'hCF);
      wr(4'h0, 8'h01);
      bus(4'h0, 1'b1, 8'h40, 4'h0);
      rd(4'h0, 32'h01);
      rd(4'h2, 32'h00);
      $display("test normal done");
      wr(4'h8, 8'h05);
      wr(4'h8, 8'h0A);
      rd(4'h8, 32'h05);
      chk({24'h0, watchdog_control_reg}, 32'h05);
      wr(4'h0, 8'h00);
      rd(4'h0, 32'h01);
      osc_good_status <= 1'b0;
      nap(6);
      rd(4'h0, 32'h80);
      osc_good_status <= 1'b1;
      nap(6);
      wr(4'h0, 8'h01);
      rd(4'h0, 32'h01);
      wr(4'h0, 8'h00);
      rd(4'h0, 32'h01);
      rd(4'hC, 32'h09);
      $display("test watchdog done");
      wr(4'h4, 8'h01);
      wr(4'h0, 8'hC0);
      rd(4'h0, 32'h01);
      wr(4'h4, 8'h00);
      special_mode <= 1'b1;
      nap(6);
      wr(4'h0, 8'h00);
      rd(4'h0, 32'h00);
      special_mode <= 1'b0;
      nap(6);
      $display("test gates done");
      stop_request <= 1'b1;
      nap(8);
      chk({30'h0, full_stop, osc_run}, 32'h2);
      rd(4'h0, 32'h80);
      stop_request <= 1'b0;
      nap(6);
      wr(4'h0, 8'h40);
      nap(6);
      stop_request <= 1'b1;
      nap(8);
      chk({30'h0, pseudo_stop, osc_run}, 32'h3);
      stop_request <= 1'b0;
      nap(6);
      $display("test stop done");
      tally_and_finish();
   end
endmodule : system_clock_source_select_tb
`default_nettype wire
